// *** hw/aux_readback_pkg.sv ***
package aux_readback_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int LVL_W = 5;
   localparam int CODE_W = 4;
   localparam int TALLY_W = 8;

   localparam logic [ADDR_W-1:0] OFS_USER_OVERFLOW = 12'h110;
   localparam logic [ADDR_W-1:0] OFS_RAW_LEVELS = 12'h130;
   localparam logic [ADDR_W-1:0] OFS_BYTE_POP = 12'h134;
   localparam logic [ADDR_W-1:0] OFS_RESP_CODE = 12'h138;
   localparam logic [ADDR_W-1:0] OFS_RESP_TALLY = 12'h13C;
   localparam logic [ADDR_W-1:0] OFS_REPLY_STATUS = 12'h14C;

   localparam int BIT_OVERFLOW = 0;
   localparam int BIT_HOT_PLUG = 0;
   localparam int BIT_REQUEST = 1;
   localparam int BIT_REPLY = 2;
   localparam int BIT_TIMEOUT = 3;
   localparam int BIT_RECEIVED = 0;

   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
   localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
   localparam logic [LVL_W-1:0] LVL_ZERO = 5'h00;
   localparam logic [LVL_W-1:0] LVL_ONE = 5'h01;
   localparam logic [LVL_W-1:0] LVL_FULL = 5'h10;
   localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;
   localparam logic [TALLY_W-1:0] TALLY_ZERO = 8'h00;
   localparam logic [TALLY_W-1:0] TALLY_ONE = 8'h01;

   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_POP,
      SEL_WORD
   } rd_sel_t;
endpackage

// *** hw/reply_byte_mem.sv ***
`timescale 1ns/1ps
module reply_byte_mem
   import aux_readback_pkg::*;
(
   input wire logic clk_sys,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [PTR_W-1:0] wr_addr,
   input wire logic [BYTE_W-1:0] wr_data,
   input wire logic [PTR_W-1:0] rd_addr,
   output logic [BYTE_W-1:0] rd_data_r
);
   logic [BYTE_W-1:0] mem_r [FIFO_DEPTH];

   genvar g;
   generate
      for (g = 0; g < FIFO_DEPTH; g++) begin : g_entry
         always_ff @(posedge clk_sys) begin
            if (ce && wr_en && wr_addr == PTR_W'(g)) begin
               mem_r[g] <= wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (ce) begin
         rd_data_r <= mem_r[rd_addr];
      end
   end
endmodule

// *** hw/reply_tally.sv ***
`timescale 1ns/1ps
module reply_tally
   import aux_readback_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic clr,
   input wire logic inc,
   output logic [TALLY_W-1:0] count_r
);
   logic [TALLY_W-1:0] count_nxt;

   always_comb begin
      count_nxt = count_r;
      if (clr) begin
         count_nxt = TALLY_ZERO; // R12
      end
      if (inc) begin
         // Wraps at the top; a reply in the clearing cycle still counts
         count_nxt = clr ? TALLY_ONE : count_r + TALLY_ONE; // R11 R13
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_r <= TALLY_ZERO;
      end else if (ce) begin
         count_r <= count_nxt;
      end
   end
endmodule

// *** hw/aux_reply_status_readback.sv ***
`timescale 1ns/1ps
// Contract
// R1: Overflow flag sets on user FIFO overflow, clears when software reads it.
// R2: Raw bit 3 reads 1 after a reply deadline expired without reply.
// R3: Raw bit 2 reads 1 while a reply is being received.
// R4: Raw bit 1 reads 1 while a request is being transmitted.
// R5: Raw bit 0 returns the unfiltered hot-plug pin level.
// R6: Reply bytes stored in a 16-entry FIFO, read one byte in bits 7:0.
// R7: Reply bytes read back in arrival order, byte 0 first.
// R8: Bytes placed in the FIFO equal the count the request asked for.
// R9: Code register holds latest native code in 1:0, I2C code in 3:2.
// R10: No automatic retry after defer or not-acknowledge; software reissues.
// R11: Eight-bit counter increments once per received reply, readable.
// R12: Any write to the reply count register clears the counter.
// R13: Reply counter wraps from 255 to 0.
// R14: Reading empty reply FIFO returns zero, leaves FIFO unchanged.
// R15: Reply-received bit clears at request start, sets on valid complete reply.
module aux_reply_status_readback
   import aux_readback_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata_r,
   output logic reg_rvalid_r,
   input wire logic hot_plug_pin_level,
   input wire logic request_start,
   input wire logic [PTR_W-1:0] request_len,
   input wire logic request_active,
   input wire logic reply_active,
   input wire logic reply_deadline_expired,
   input wire logic reply_byte_valid,
   input wire logic [BYTE_W-1:0] reply_byte,
   input wire logic reply_done,
   input wire logic reply_ok,
   input wire logic [CODE_W-1:0] reply_code,
   input wire logic user_fifo_overflow,
   output logic reply_received_r,
   output logic overflow_flag_r
);
   // Reply FIFO state
   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [LVL_W-1:0] level_r, level_nxt;
   logic [LVL_W-1:0] budget_r, budget_nxt;
   logic push, pop, fifo_empty;
   logic [BYTE_W-1:0] mem_rd_data;

   // Status state
   logic [CODE_W-1:0] code_r, code_nxt;
   logic timeout_r, timeout_nxt;
   logic received_nxt;
   logic overflow_nxt;
   logic [TALLY_W-1:0] tally;
   logic tally_clr, tally_inc;

   // Read pipeline
   rd_sel_t sel_r, sel_nxt;
   logic [DATA_W-1:0] word_r, word_nxt;
   logic [DATA_W-1:0] rdata_nxt;
   logic rvalid_nxt;
   logic stage_r, stage_nxt;
   logic rd_pop_hit, rd_ovf_hit;

   assign fifo_empty = (level_r == LVL_ZERO);
   assign rd_pop_hit = reg_rd && reg_addr == OFS_BYTE_POP;
   assign rd_ovf_hit = reg_rd && reg_addr == OFS_USER_OVERFLOW;
   // Extra bytes beyond the requested length are dropped
   assign push = reply_byte_valid && !request_start && level_r != LVL_FULL && budget_r != LVL_ZERO; // R6 R8
   assign pop = rd_pop_hit && !fifo_empty && !request_start; // R14
   assign tally_clr = reg_wr && reg_addr == OFS_RESP_TALLY; // R12
   assign tally_inc = reply_done; // R11

   reply_byte_mem u_mem (
      .clk_sys(clk_sys),
      .ce(ce),
      .wr_en(push),
      .wr_addr(wr_ptr_r),
      .wr_data(reply_byte),
      .rd_addr(rd_ptr_r),
      .rd_data_r(mem_rd_data)
   );

   reply_tally u_tally (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .clr(tally_clr),
      .inc(tally_inc),
      .count_r(tally)
   );

   // FIFO pointers; a new request flushes old reply bytes
   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      level_nxt = level_r;
      budget_nxt = budget_r;
      if (request_start) begin
         wr_ptr_nxt = PTR_ZERO;
         rd_ptr_nxt = PTR_ZERO;
         level_nxt = LVL_ZERO;
         budget_nxt = LVL_W'(request_len) + LVL_ONE; // R8
      end else begin
         if (push) begin
            wr_ptr_nxt = wr_ptr_r + PTR_ONE; // R7
            budget_nxt = budget_r - LVL_ONE;
         end
         if (pop) begin
            rd_ptr_nxt = rd_ptr_r + PTR_ONE; // R7
         end
         case ({push, pop})
            2'h2: level_nxt = level_r + LVL_ONE;
            2'h1: level_nxt = level_r - LVL_ONE;
            default: level_nxt = level_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr_r <= PTR_ZERO;
         rd_ptr_r <= PTR_ZERO;
         level_r <= LVL_ZERO;
         budget_r <= LVL_ZERO;
      end else if (ce) begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         level_r <= level_nxt;
         budget_r <= budget_nxt;
      end
   end

   // Status flags; hardware set wins over any clear in the same cycle
   always_comb begin
      code_nxt = code_r;
      timeout_nxt = timeout_r;
      received_nxt = reply_received_r;
      overflow_nxt = overflow_flag_r;
      if (reply_done) begin
         code_nxt = reply_code; // R9
      end
      // Only reflects the code; reissue stays with software
      if (request_start) begin // R10
         timeout_nxt = 1'b0;
         received_nxt = 1'b0; // R15
      end
      if (reply_deadline_expired) begin
         timeout_nxt = 1'b1; // R2
      end
      if (reply_done && reply_ok) begin
         received_nxt = 1'b1; // R15
      end
      if (rd_ovf_hit) begin
         overflow_nxt = 1'b0; // R1
      end
      if (user_fifo_overflow) begin
         overflow_nxt = 1'b1; // R1
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         code_r <= CODE_RESET;
         timeout_r <= 1'b0;
         reply_received_r <= 1'b0;
         overflow_flag_r <= 1'b0;
      end else if (ce) begin
         code_r <= code_nxt;
         timeout_r <= timeout_nxt;
         reply_received_r <= received_nxt;
         overflow_flag_r <= overflow_nxt;
      end
   end

   // Read stage 1: pick the word, memory fetches the popped byte
   always_comb begin
      word_nxt = ZERO_WORD;
      sel_nxt = SEL_NONE;
      stage_nxt = reg_rd;
      if (reg_rd) begin
         sel_nxt = SEL_WORD;
         case (reg_addr)
            OFS_USER_OVERFLOW: begin
               word_nxt[BIT_OVERFLOW] = overflow_flag_r; // R1
            end
            OFS_RAW_LEVELS: begin
               word_nxt[BIT_HOT_PLUG] = hot_plug_pin_level; // R5
               word_nxt[BIT_REQUEST] = request_active; // R4
               word_nxt[BIT_REPLY] = reply_active; // R3
               word_nxt[BIT_TIMEOUT] = timeout_r; // R2
            end
            OFS_BYTE_POP: begin
               // Empty read answers zero
               sel_nxt = pop ? SEL_POP : SEL_WORD; // R14
            end
            OFS_RESP_CODE: begin
               word_nxt[CODE_W-1:0] = code_r; // R9
            end
            OFS_RESP_TALLY: begin
               word_nxt[TALLY_W-1:0] = tally; // R11
            end
            OFS_REPLY_STATUS: begin
               word_nxt[BIT_RECEIVED] = reply_received_r; // R15
            end
            default: begin
               word_nxt = ZERO_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sel_r <= SEL_NONE;
         word_r <= ZERO_WORD;
         stage_r <= 1'b0;
      end else if (ce) begin
         sel_r <= sel_nxt;
         word_r <= word_nxt;
         stage_r <= stage_nxt;
      end
   end

   // Read stage 2: register the answer
   always_comb begin
      rvalid_nxt = stage_r;
      rdata_nxt = reg_rdata_r;
      case (sel_r)
         SEL_POP: rdata_nxt = {{(DATA_W - BYTE_W){1'b0}}, mem_rd_data}; // R6
         SEL_WORD: rdata_nxt = word_r;
         SEL_NONE: rdata_nxt = reg_rdata_r;
         default: rdata_nxt = ZERO_WORD;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata_r <= ZERO_WORD;
         reg_rvalid_r <= 1'b0;
      end else if (ce) begin
         reg_rdata_r <= rdata_nxt;
         reg_rvalid_r <= rvalid_nxt;
      end
   end
endmodule

// *** bench/aux_reply_chk.sv ***
`timescale 1ns/1ps
module aux_reply_chk
   import aux_readback_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata_r,
   input wire logic reg_rvalid_r,
   input wire logic request_start,
   input wire logic reply_done,
   input wire logic reply_ok,
   input wire logic user_fifo_overflow,
   input wire logic reply_received_r,
   input wire logic overflow_flag_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire ok_done = ce && reply_done && reply_ok;
   wire ovf_rd = ce && reg_rd && reg_addr == OFS_USER_OVERFLOW;
   sequence s_read; ce && reg_rd; endsequence
   sequence s_answer; ##[2:3] reg_rvalid_r; endsequence
   a_read_answer: assert property (s_read |-> s_answer) else $error("read not answered");
   a_rdata_hold: assert property (!reg_rvalid_r |-> $stable(reg_rdata_r)) else $error("read data moved");
   a_ovf_set: assert property (ce && user_fifo_overflow |=> overflow_flag_r) else $error("overflow not set");
   a_ovf_clear: assert property (ovf_rd && !user_fifo_overflow |=> !overflow_flag_r) else $error("overflow kept");
   a_ovf_hold: assert property (overflow_flag_r && !ovf_rd |=> overflow_flag_r) else $error("overflow lost");
   a_rcv_set: assert property (ok_done |=> reply_received_r) else $error("received not set");
   a_rcv_clear: assert property (ce && request_start && !ok_done |=> !reply_received_r) else $error("received kept");
   a_rcv_hold: assert property (reply_received_r && !(ce && request_start) |=> reply_received_r) else $error("received lost");
endmodule
bind aux_reply_status_readback aux_reply_chk i_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .request_start(request_start),
   .reply_done(reply_done), .reply_ok(reply_ok), .user_fifo_overflow(user_fifo_overflow),
   .reply_received_r(reply_received_r), .overflow_flag_r(overflow_flag_r));

// *** bench/sink_reply_model.sv ***
`timescale 1ns/1ps
module sink_reply_model
   import aux_readback_pkg::*;
(
   input wire logic clk_sys,
   input wire logic go,
   input wire logic silent,
   input wire logic [PTR_W-1:0] len,
   input wire logic [CODE_W-1:0] code,
   output logic busy = 1'b0,
   output logic request_start = 1'b0,
   output logic [PTR_W-1:0] request_len = 4'h0,
   output logic request_active = 1'b0,
   output logic reply_active = 1'b0,
   output logic reply_deadline_expired = 1'b0,
   output logic reply_byte_valid = 1'b0,
   output logic [BYTE_W-1:0] reply_byte = 8'h00,
   output logic reply_done = 1'b0,
   output logic reply_ok = 1'b0,
   output logic [CODE_W-1:0] reply_code = 4'h0
);
   always @(posedge clk_sys) begin
      if (go) begin
         {busy, request_start, request_active, request_len} <= {3'h7, len};
         @(posedge clk_sys);
         {request_start, request_len} <= {1'b0, ~len};
         repeat (3) @(posedge clk_sys);
         request_active <= 1'b0;
         if (silent) begin
            reply_deadline_expired <= 1'b1;
         end else begin
            reply_active <= 1'b1;
            // One byte beyond the requested count
            for (int i = 0; i <= len + 1; i++) begin
               {reply_byte_valid, reply_byte} <= {1'b1, 8'hA0 + i[7:0]};
               @(posedge clk_sys);
            end
            {reply_byte_valid, reply_byte} <= {1'b0, ~reply_byte};
            {reply_done, reply_ok, reply_code} <= {2'h3, code};
         end
         @(posedge clk_sys);
         {reply_done, reply_ok, reply_deadline_expired, reply_active, busy} <= 5'h00;
         reply_code <= ~code;
      end
   end
endmodule

// *** bench/tb_aux_reply_status_readback.sv ***
`timescale 1ns/1ps
module tb_aux_reply_status_readback
   import aux_readback_pkg::*;
;
   logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, hot = 1'b0, ovf = 1'b0, go = 1'b0;
   logic silent = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 12'h000;
   logic [DATA_W-1:0] reg_wdata = 32'h0000_0000, reg_rdata_r;
   logic [PTR_W-1:0] len = 4'h0, request_len;
   logic [CODE_W-1:0] code = 4'h0, reply_code;
   logic [BYTE_W-1:0] reply_byte;
   logic reg_rvalid_r, busy, request_start, request_active, reply_active, reply_deadline_expired;
   logic reply_byte_valid, reply_done, reply_ok, reply_received_r, overflow_flag_r;
   logic [CODE_W-1:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
   int fail_count = 0, checked = 0, cyc = 0, t = 0;
   initial forever #50 clk_sys = ~clk_sys;
   aux_reply_status_readback i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
      .hot_plug_pin_level(hot), .request_start(request_start), .request_len(request_len),
      .request_active(request_active), .reply_active(reply_active), .reply_deadline_expired(reply_deadline_expired),
      .reply_byte_valid(reply_byte_valid), .reply_byte(reply_byte), .reply_done(reply_done), .reply_ok(reply_ok),
      .reply_code(reply_code), .user_fifo_overflow(ovf), .reply_received_r(reply_received_r),
      .overflow_flag_r(overflow_flag_r));
   sink_reply_model i_sink (.clk_sys(clk_sys), .go(go), .silent(silent), .len(len), .code(code), .busy(busy),
      .request_start(request_start), .request_len(request_len), .request_active(request_active),
      .reply_active(reply_active), .reply_deadline_expired(reply_deadline_expired),
      .reply_byte_valid(reply_byte_valid), .reply_byte(reply_byte), .reply_done(reply_done), .reply_ok(reply_ok),
      .reply_code(reply_code));
   task chk(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      int n;
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      n = 0;
      while (reg_rvalid_r !== 1'b1 && n < 8) begin
         @(posedge clk_sys);
         n++;
      end
      chk(nm, exp, (n < 8) ? reg_rdata_r : ~exp);
   endtask
   task xfer(input logic [PTR_W-1:0] l, input logic [CODE_W-1:0] c, input logic s);
      {len, code, silent, go} <= {l, c, s, 1'b1};
      @(posedge clk_sys);
      go <= 1'b0;
   endtask
   task idle;
      int n;
      n = 0;
      @(posedge clk_sys);
      while (busy && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
   endtask
   task tend;
      t++;
      $display("test %0d done", t);
   endtask
   task complete_run;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 12000) begin
         fail_count++;
         complete_run;
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk("reset flags", 32'h0, {29'h0, reg_rvalid_r, reply_received_r, overflow_flag_r});
      rdchk("tally", OFS_RESP_TALLY, 32'h0);
      rdchk("empty pop", OFS_BYTE_POP, 32'h0);
      rdchk("unmapped", 12'h200, 32'h0);
      hot <= 1'b1;
      rdchk("raw hot plug", OFS_RAW_LEVELS, 32'h1);
      hot <= 1'b0;
      tend;
      for (int k = 0; k < 5; k++) begin
         xfer(4'h2, codes[k], 1'b0);
         idle;
         chk("received", 32'h1, {31'h0, reply_received_r});
         rdchk("code", OFS_RESP_CODE, {28'h0, codes[k]});
         for (int b = 0; b < 3; b++) rdchk("pop", OFS_BYTE_POP, 32'hA0 + b);
         rdchk("excess pop", OFS_BYTE_POP, 32'h0);
         rdchk("tally", OFS_RESP_TALLY, 32'(k + 1));
      end
      tend;
      xfer(4'hF, 4'h0, 1'b0);
      rdchk("raw request", OFS_RAW_LEVELS, 32'h2);
      repeat (2) @(posedge clk_sys);
      rdchk("raw reply", OFS_RAW_LEVELS, 32'h4);
      idle;
      for (int b = 0; b < 16; b++) rdchk("full pop", OFS_BYTE_POP, 32'hA0 + b);
      rdchk("beyond full", OFS_BYTE_POP, 32'h0);
      xfer(4'h1, 4'h0, 1'b1);
      idle;
      chk("received", 32'h0, {31'h0, reply_received_r});
      rdchk("raw timeout", OFS_RAW_LEVELS, 32'h8);
      tend;
      reg_wdata <= 32'hFFFF_FFFF;
      reg_addr <= OFS_RESP_TALLY;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
      rdchk("tally clear", OFS_RESP_TALLY, 32'h0);
      repeat (257) begin
         xfer(4'h0, 4'h1, 1'b0);
         idle;
      end
      rdchk("tally wrap", OFS_RESP_TALLY, 32'h1);
      // Write while frozen must not be taken
      ce <= 1'b0;
      reg_addr <= OFS_RESP_TALLY;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      ce <= 1'b1;
      reg_wr <= 1'b0;
      rdchk("tally frozen", OFS_RESP_TALLY, 32'h1);
      tend;
      ovf <= 1'b1;
      @(posedge clk_sys);
      ovf <= 1'b0;
      @(posedge clk_sys);
      chk("overflow flag", 32'h1, {31'h0, overflow_flag_r});
      rdchk("overflow", OFS_USER_OVERFLOW, 32'h1);
      chk("overflow cleared", 32'h0, {31'h0, overflow_flag_r});
      // Event in the reading cycle wins over the clear
      ovf <= 1'b1;
      rdchk("overflow set wins", OFS_USER_OVERFLOW, 32'h0);
      ovf <= 1'b0;
      rdchk("overflow kept", OFS_USER_OVERFLOW, 32'h1);
      rdchk("overflow clear", OFS_USER_OVERFLOW, 32'h0);
      tend;
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk("flags after reset", 32'h0, {30'h0, reply_received_r, overflow_flag_r});
      rdchk("tally after reset", OFS_RESP_TALLY, 32'h0);
      rdchk("pop after reset", OFS_BYTE_POP, 32'h0);
      tend;
      complete_run;
   end
endmodule
